// ---- include/dma_ctrl_pkg.sv ----
// Function
// - next-block length is 16-bit rw, write sets valid
// - zero length means 65535 transfer cycles
// - writing enable one starts; clearing stops channel
// - clock enabled only while some channel enabled
// - interrupt from enabled terminal-count or overrun flags
// - size select: byte or 16-bit word cycles
// - mode select: fly-by or memory-to-memory
// - direction: device A source (read) or destination (write)
// - auto-init select: buffered or auto-initialize mode
// - bus policy: release each cycle or hold bus
// - soft request bit raises request, reads back
// - device A address steps by encoded step
// - device B address steps by encoded step, in memory-to-memory mode only
// - status byte layout, upper bits zero, reset clear
// - sticky flags cleared only by writing one
// - terminal count set when block counter reaches zero
// - overrun on completion per operating mode
// - channel active is enable and nonzero counter
// - completion with valid set or auto-init reloads counters and clears valid
// - block counter decrements each transfer cycle
// - interrupts are levels while flag stays set
// - debug halt pauses all transfers
package dma_ctrl_pkg;
    localparam int ADDR_W = 24;
    localparam int LEN_W  = 16;
    localparam int CTRL_W = 16;
    localparam int DATA_W = 32;

    // per-channel word index, channel in bits above
    localparam int REG_IDX_LSB   = 2;
    localparam int CH_STRIDE_LSB = 5;
    localparam logic [2:0] REG_ADDR_A_CNT = 3'h0;
    localparam logic [2:0] REG_ADDR_A_RLD = 3'h1;
    localparam logic [2:0] REG_ADDR_B_CNT = 3'h2;
    localparam logic [2:0] REG_ADDR_B_RLD = 3'h3;
    localparam logic [2:0] REG_BLOCK_CNT  = 3'h4;
    localparam logic [2:0] REG_NEXT_LEN   = 3'h5;
    localparam logic [2:0] REG_CONTROL    = 3'h6;
    localparam logic [2:0] REG_STATUS     = 3'h7;

    // control word fields
    localparam int CB_ENABLE   = 0;
    localparam int CB_ETC      = 1;
    localparam int CB_OVERRUN_IRQ_ENABLE     = 2;
    localparam int CB_SIZE     = 3;
    localparam int CB_M2M      = 4;
    localparam int CB_WAY      = 5;
    localparam int CB_AUTO     = 6;
    localparam int CB_POLICY   = 7;
    localparam int CB_SOFT_REQ = 8;
    localparam int CB_A_UPD    = 9;
    localparam int CB_A_STEP   = 10;
    localparam int CB_B_UPD    = 12;
    localparam int CB_B_STEP   = 13;
    localparam logic [CTRL_W-1:0] CTRL_WR_MASK = 16'h7FFF;

    // status byte fields
    localparam int SB_TC     = 0;
    localparam int SB_OVR    = 1;
    localparam int SB_ACTIVE = 2;
    localparam int SB_VALID  = 3;

    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [LEN_W-1:0]  LEN_RST  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
    localparam logic [LEN_W-1:0]  LEN_MAX  = 16'hFFFF;
    localparam logic [LEN_W-1:0]  LEN_ONE  = 16'h0001;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h00_0001;
    localparam logic [ADDR_W-1:0] ADDR_TWO = 24'h00_0002;

    localparam logic [1:0] STEP_INC1 = 2'h0;
    localparam logic [1:0] STEP_INC2 = 2'h1;
    localparam logic [1:0] STEP_DEC1 = 2'h2;
    localparam logic [1:0] STEP_DEC2 = 2'h3;
endpackage

// ---- rtl/dma_channel_control_status.sv ----
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
module dma_channel_control_status
    import dma_ctrl_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // wishbone slave
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [$clog2(NUM_CH)+CH_STRIDE_LSB-1:0] wb_adr_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [DATA_W-1:0]                    wb_dat_i,
    output logic      [DATA_W-1:0]                    wb_dat_o,
    output logic                                      wb_ack_o,
    // requests and debug
    input  wire logic [NUM_CH-1:0]                    hw_transfer_request,
    input  wire logic                                 debug_halt,
    // transfer cycle towards the system bus
    output logic                                      xfer_valid,
    output logic      [$clog2(NUM_CH)-1:0]            xfer_channel,
    output logic      [ADDR_W-1:0]                    xfer_addr_a,
    output logic      [ADDR_W-1:0]                    xfer_addr_b,
    output logic                                      xfer_write,
    output logic                                      xfer_word,
    output logic                                      xfer_indirect,
    output logic      [NUM_CH-1:0]                    bus_hold,
    // interrupts and clock gate
    output logic      [NUM_CH-1:0]                    chan_irq,
    output logic                                      clock_enable
);
    localparam int CH_W = $clog2(NUM_CH);

    typedef struct packed {
        logic [NUM_CH-1:0][ADDR_W-1:0] a_cnt;
        logic [NUM_CH-1:0][ADDR_W-1:0] a_rld;
        logic [NUM_CH-1:0][ADDR_W-1:0] b_cnt;
        logic [NUM_CH-1:0][ADDR_W-1:0] b_rld;
        logic [NUM_CH-1:0][LEN_W-1:0]  blc;
        logic [NUM_CH-1:0][LEN_W-1:0]  nbl;
        logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;
        logic [NUM_CH-1:0]             vld;
        logic [NUM_CH-1:0]             overrun_flag;
        logic [NUM_CH-1:0]             tc;
        logic [NUM_CH-1:0]             rest;
        logic [NUM_CH-1:0]             hold;
        logic [NUM_CH-1:0]             irq;
        logic                          ack;
        logic [DATA_W-1:0]             rdata;
        logic                          xv;
        logic [CH_W-1:0]               xch;
        logic [ADDR_W-1:0]             xa;
        logic [ADDR_W-1:0]             xb;
        logic                          xw;
        logic                          xword;
        logic                          xind;
        logic                          xpol;
        logic                          clk_en;
    } state_s;

    state_s q;
    state_s d;

    logic                  acc;
    logic                  wr;
    logic                  mapped;
    logic [CH_W-1:0]       sel_ch;
    logic [2:0]            sel_reg;
    logic [DATA_W-1:0]     wmix;
    logic [NUM_CH-1:0]     req;
    logic [NUM_CH-1:0]     active;
    logic [NUM_CH-1:0]     done;
    logic [NUM_CH-1:0]     start;
    logic [NUM_CH-1:0]     wr_nbl;
    logic [NUM_CH-1:0]     wr_stat;
    logic                  found;
    logic [CH_W-1:0]       gch;
    logic [CTRL_W-1:0]     gc;

    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic en,
                                                   input logic [1:0] code);
        logic [ADDR_W-1:0] r;
        r = a;
        if (en) begin
            case (code)
                STEP_INC1: r = a + ADDR_ONE;
                STEP_INC2: r = a + ADDR_TWO;
                STEP_DEC1: r = a - ADDR_ONE;
                default:   r = a - ADDR_TWO;
            endcase
        end
        return r;
    endfunction

    // a zero length is the longest block, so the counter never idles at zero after a load
    function automatic logic [LEN_W-1:0] fix_len(input logic [LEN_W-1:0] v);
        return (v == LEN_RST) ? LEN_MAX : v;
    endfunction

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                               input logic [3:0] sel);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        d       = q;
        d.ack   = 1'b0;
        d.xv    = 1'b0;
        d.hold  = '0;
        acc     = wb_cyc_i && wb_stb_i && !q.ack;
        wr      = acc && wb_we_i;
        sel_ch  = wb_adr_i[CH_STRIDE_LSB +: CH_W];
        sel_reg = wb_adr_i[REG_IDX_LSB +: 3];
        mapped  = (wb_adr_i[1:0] == 2'h0) && (int'(sel_ch) < NUM_CH);
        wmix    = '0;
        done    = '0;
        start   = '0;
        wr_nbl  = '0;
        wr_stat = '0;
        found   = 1'b0;
        gch     = '0;
        gc      = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            req[i]    = hw_transfer_request[i] || q.ctrl[i][CB_SOFT_REQ];
            active[i] = q.ctrl[i][CB_ENABLE] && (q.blc[i] != LEN_RST);
        end

        // fixed priority, lowest channel first
        for (int i = 0; i < NUM_CH; i++) begin
            if (!found && active[i] && req[i] && !q.rest[i]) begin
                found = 1'b1;
                gch   = CH_W'(i);
            end
        end
        // halt freezes the rest state too, so a paused channel resumes as it stood
        d.rest = debug_halt ? q.rest : '0;
        if (found && !debug_halt) begin
            gc       = q.ctrl[gch];
            d.xv     = 1'b1;
            d.xch    = gch;
            d.xa     = q.a_cnt[gch];
            d.xb     = q.b_cnt[gch];
            d.xw     = gc[CB_WAY];
            d.xword  = gc[CB_SIZE];
            d.xind   = gc[CB_M2M];
            d.xpol   = gc[CB_POLICY];
            d.blc[gch]   = q.blc[gch] - LEN_ONE;
            d.a_cnt[gch] = step_addr(q.a_cnt[gch], gc[CB_A_UPD], gc[CB_A_STEP +: 2]);
            if (gc[CB_M2M]) begin
                d.b_cnt[gch] = step_addr(q.b_cnt[gch], gc[CB_B_UPD], gc[CB_B_STEP +: 2]);
            end
            d.rest[gch] = !gc[CB_POLICY];
            d.hold[gch] = gc[CB_POLICY] && req[gch];
            done[gch]   = (q.blc[gch] == LEN_ONE);
        end

        if (wr && mapped && sel_reg == REG_CONTROL) begin
            wmix = merge({16'h0000, q.ctrl[sel_ch]}, wb_dat_i, wb_sel_i);
            d.ctrl[sel_ch] = wmix[CTRL_W-1:0] & CTRL_WR_MASK;
            start[sel_ch]  = wb_sel_i[0] && wb_dat_i[CB_ENABLE];
        end

        // completion, or a fresh enable on an idle channel with parameters waiting
        for (int i = 0; i < NUM_CH; i++) begin
            if ((done[i] && (q.ctrl[i][CB_AUTO] || q.vld[i])) ||
                (start[i] && q.blc[i] == LEN_RST && q.vld[i])) begin
                d.blc[i]   = fix_len(q.nbl[i]);
                d.a_cnt[i] = q.a_rld[i];
                if (q.ctrl[i][CB_M2M]) begin
                    d.b_cnt[i] = q.b_rld[i];
                end
            end
        end

        if (wr && mapped) begin
            if (sel_reg == REG_ADDR_A_CNT) begin
                wmix = merge({8'h00, q.a_cnt[sel_ch]}, wb_dat_i, wb_sel_i);
                d.a_cnt[sel_ch] = wmix[ADDR_W-1:0];
            end else if (sel_reg == REG_ADDR_A_RLD) begin
                wmix = merge({8'h00, q.a_rld[sel_ch]}, wb_dat_i, wb_sel_i);
                d.a_rld[sel_ch] = wmix[ADDR_W-1:0];
            end else if (sel_reg == REG_ADDR_B_CNT) begin
                wmix = merge({8'h00, q.b_cnt[sel_ch]}, wb_dat_i, wb_sel_i);
                d.b_cnt[sel_ch] = wmix[ADDR_W-1:0];
            end else if (sel_reg == REG_ADDR_B_RLD) begin
                wmix = merge({8'h00, q.b_rld[sel_ch]}, wb_dat_i, wb_sel_i);
                d.b_rld[sel_ch] = wmix[ADDR_W-1:0];
            end else if (sel_reg == REG_BLOCK_CNT) begin
                wmix = merge({16'h0000, q.blc[sel_ch]}, wb_dat_i, wb_sel_i);
                d.blc[sel_ch] = fix_len(wmix[LEN_W-1:0]);
            end else if (sel_reg == REG_NEXT_LEN) begin
                wmix = merge({16'h0000, q.nbl[sel_ch]}, wb_dat_i, wb_sel_i);
                d.nbl[sel_ch]  = wmix[LEN_W-1:0];
                wr_nbl[sel_ch] = 1'b1;
            end else if (sel_reg == REG_STATUS) begin
                wr_stat[sel_ch] = wb_sel_i[0];
            end
        end

        // hardware sets win over software clears in the same cycle
        for (int i = 0; i < NUM_CH; i++) begin
            d.vld[i] = (q.vld[i] && !(wr_stat[i] && wb_dat_i[SB_VALID]) &&
                        !(done[i] && (q.ctrl[i][CB_AUTO] || q.vld[i])) &&
                        !(start[i] && q.blc[i] == LEN_RST)) || wr_nbl[i];
            d.tc[i]  = (q.tc[i] && !(wr_stat[i] && wb_dat_i[SB_TC])) || done[i];
            d.overrun_flag[i] = (q.overrun_flag[i] && !(wr_stat[i] && wb_dat_i[SB_OVR])) ||
                       (done[i] && (q.ctrl[i][CB_AUTO] ? q.tc[i] : !q.vld[i]));
            d.irq[i] = (d.tc[i] && d.ctrl[i][CB_ETC]) || (d.overrun_flag[i] && d.ctrl[i][CB_OVERRUN_IRQ_ENABLE]);
        end

        d.clk_en = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            d.clk_en = d.clk_en || d.ctrl[i][CB_ENABLE];
        end

        if (acc) begin
            d.ack   = 1'b1;
            d.rdata = '0;
            if (!mapped) begin
                d.rdata = '0;
            end else if (sel_reg == REG_ADDR_A_CNT) begin
                d.rdata = {8'h00, q.a_cnt[sel_ch]};
            end else if (sel_reg == REG_ADDR_A_RLD) begin
                d.rdata = {8'h00, q.a_rld[sel_ch]};
            end else if (sel_reg == REG_ADDR_B_CNT) begin
                d.rdata = {8'h00, q.b_cnt[sel_ch]};
            end else if (sel_reg == REG_ADDR_B_RLD) begin
                d.rdata = {8'h00, q.b_rld[sel_ch]};
            end else if (sel_reg == REG_BLOCK_CNT) begin
                d.rdata = {16'h0000, q.blc[sel_ch]};
            end else if (sel_reg == REG_NEXT_LEN) begin
                d.rdata = {16'h0000, q.nbl[sel_ch]};
            end else if (sel_reg == REG_CONTROL) begin
                d.rdata = {16'h0000, q.ctrl[sel_ch]};
            end else begin
                d.rdata = {24'h00_0000, 4'h0, q.vld[sel_ch], active[sel_ch],
                           q.overrun_flag[sel_ch], q.tc[sel_ch]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o      = q.rdata;
    assign wb_ack_o      = q.ack;
    assign xfer_valid    = q.xv;
    assign xfer_channel  = q.xch;
    assign xfer_addr_a   = q.xa;
    assign xfer_addr_b   = q.xb;
    assign xfer_write    = q.xw;
    assign xfer_word     = q.xword;
    assign xfer_indirect = q.xind;
    assign bus_hold      = q.hold;
    assign chan_irq      = q.irq;
    assign clock_enable  = q.clk_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ack_pulse_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack is not a single cycle pulse");
    halt_stop_a: assert property (debug_halt |=> !xfer_valid)
        else $error("transfer issued during debug halt");
    gate_clock_a: assert property ($rose(clock_enable) |-> $past(wr))
        else $error("clock enable rose without a control write");
    release_bus_a: assert property (xfer_valid && !q.xpol |=>
                                    !(xfer_valid && xfer_channel == $past(xfer_channel)))
        else $error("intermittent channel took back-to-back cycles");
    status_pad_a: assert property (wb_ack_o && $past(!wb_we_i && sel_reg == REG_STATUS) |->
                                   wb_dat_o[DATA_W-1:4] == '0)
        else $error("status read shows nonzero upper bits");

    for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_chk
        valid_set_a: assert property (wr_nbl[gi] |=> q.vld[gi] ##1 (q.vld[gi] || $past(done[gi] || wr_stat[gi]
                                      || start[gi])))
            else $error("length write did not set valid");
        tc_sticky_a: assert property (q.tc[gi] && !wr_stat[gi] |=> q.tc[gi])
            else $error("terminal count flag dropped on its own");
        tc_set_a: assert property (done[gi] |=> q.tc[gi])
            else $error("block completion did not set terminal count");
        ovr_auto_a: assert property (done[gi] && q.ctrl[gi][CB_AUTO] && q.tc[gi] |=> q.overrun_flag[gi])
            else $error("auto-init overrun not flagged");
        ovr_buf_a: assert property (done[gi] && !q.ctrl[gi][CB_AUTO] && !q.vld[gi] |=>
                                    q.overrun_flag[gi] && q.blc[gi] == LEN_RST)
            else $error("buffered overrun not flagged");
        reload_a: assert property (done[gi] && q.vld[gi] && !wr_nbl[gi] |=>
                                   !q.vld[gi] && q.blc[gi] == fix_len($past(q.nbl[gi])))
            else $error("completion did not reload counter");
        irq_level_a: assert property (q.tc[gi] && q.ctrl[gi][CB_ETC] && !wr_stat[gi] |=> chan_irq[gi])
            else $error("terminal count interrupt missing");
        irq_match_a: assert property (chan_irq[gi] ==
                                      (q.tc[gi] && q.ctrl[gi][CB_ETC] || q.overrun_flag[gi] && q.ctrl[gi][CB_OVERRUN_IRQ_ENABLE]))
            else $error("interrupt level does not follow its flags");
        disable_stop_a: assert property (!q.ctrl[gi][CB_ENABLE] |=>
                                         !(xfer_valid && xfer_channel == CH_W'(gi)))
            else $error("disabled channel issued a transfer");
        start_load_a: assert property (start[gi] && q.blc[gi] == LEN_RST && q.vld[gi] |=>
                                       q.blc[gi] == fix_len($past(q.nbl[gi])) && !q.vld[gi])
            else $error("enable on an idle channel did not load the next block");
        soft_req_a: assert property (q.ctrl[gi][CB_SOFT_REQ] && active[gi] &&
                                     !q.rest[gi] && !debug_halt |=> xfer_valid)
            else $error("software request did not start a transfer");
        hold_own_a: assert property (bus_hold[gi] |-> xfer_valid && q.xpol && xfer_channel == CH_W'(gi))
            else $error("bus held outside a burst transfer of this channel");
        xfer_attr_a: assert property (xfer_valid && xfer_channel == CH_W'(gi) |->
                                      xfer_word == $past(q.ctrl[gi][CB_SIZE]) &&
                                      xfer_indirect == $past(q.ctrl[gi][CB_M2M]) &&
                                      xfer_write == $past(q.ctrl[gi][CB_WAY]))
            else $error("transfer attributes differ from the control word");
        // a bus write in the cycle before may load the counter, so that case is left out
        count_step_a: assert property (xfer_valid && xfer_channel == CH_W'(gi) && !$past(wr) &&
                                       $past(q.blc[gi]) != LEN_ONE |-> q.blc[gi] == $past(q.blc[gi]) - LEN_ONE)
            else $error("block counter did not step down by one");
        flyby_b_a: assert property (xfer_valid && xfer_channel == CH_W'(gi) && !xfer_indirect &&
                                    !$past(wr) |-> $stable(q.b_cnt[gi]))
            else $error("fly-by transfer moved the device B counter");
    end

    done_cov_c: cover property (done[0] ##1 q.tc[0]);
    word_cov_c: cover property (xfer_valid && xfer_word && xfer_indirect);
    ovr_cov_c: cover property ($rose(q.overrun_flag[0]));
    hold_cov_c: cover property (bus_hold[0] ##1 xfer_valid);
endmodule // dma_channel_control_status

// ---- tb/dma_far_end.sv ----
`timescale 1ns/1ps
module dma_far_end (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request wishes of the bench
    input  wire logic [3:0]  req_on,
    // transfer port of the controller
    input  wire logic        xfer_valid,
    input  wire logic [1:0]  xfer_channel,
    input  wire logic [23:0] xfer_addr_a,
    input  wire logic [23:0] xfer_addr_b,
    input  wire logic        xfer_write,
    input  wire logic        xfer_word,
    input  wire logic        xfer_indirect,
    input  wire logic [3:0]  bus_hold,
    // request lines towards the controller
    output logic      [3:0]  hw_transfer_request
);
    int          xfers[4];
    int          adjacent[4];
    int          holds[4];
    logic        last_v;
    logic [1:0]  last_ch;
    logic [23:0] last_a;
    logic [23:0] last_b;
    logic [2:0]  last_kind;

    // peripherals keep a level request until the bench withdraws it
    always_ff @(posedge clk) begin
        if (rst) begin
            hw_transfer_request <= 4'h0;
            last_v              <= 1'b0;
            last_ch             <= 2'h0;
            last_a              <= 24'h00_0000;
            last_b              <= 24'h00_0000;
            last_kind           <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                xfers[i]    <= 0;
                adjacent[i] <= 0;
                holds[i]    <= 0;
            end
        end else begin
            hw_transfer_request <= req_on;
            last_v              <= xfer_valid;
            last_ch             <= xfer_channel;
            if (xfer_valid === 1'b1) begin
                xfers[xfer_channel] <= xfers[xfer_channel] + 1;
                last_a              <= xfer_addr_a;
                last_b              <= xfer_addr_b;
                last_kind           <= {xfer_indirect, xfer_write, xfer_word};
                // back to back cycles on one channel show the bus was kept
                if (last_v === 1'b1 && last_ch === xfer_channel) begin
                    adjacent[xfer_channel] <= adjacent[xfer_channel] + 1;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (bus_hold[i] === 1'b1) begin
                    holds[i] <= holds[i] + 1;
                end
            end
        end
    end
endmodule // dma_far_end

// ---- tb/dma_channel_control_status_test.sv ----
`timescale 1ns/1ps
module dma_channel_control_status_test;
    import dma_ctrl_pkg::*;
    logic        clk, rst, cyc, stb, we, debug_halt, ack, xv, clock_enable;
    logic [6:0]  adr;
    logic [3:0]  sel, req_on, hw_req, hold, irq;
    logic [31:0] wdat, rdat, rd;
    logic [1:0]  xch;
    logic [23:0] xa, xb;
    logic        xw, xwd, xi;
    int          fails, check_count;

    dma_channel_control_status #(.NUM_CH(4)) dma_channel_control_status_i (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .hw_transfer_request(hw_req), .debug_halt(debug_halt), .xfer_valid(xv), .xfer_channel(xch),
        .xfer_addr_a(xa), .xfer_addr_b(xb), .xfer_write(xw), .xfer_word(xwd), .xfer_indirect(xi),
        .bus_hold(hold), .chan_irq(irq), .clock_enable(clock_enable));

    dma_far_end dma_far_end_i (
        .clk(clk), .rst(rst), .req_on(req_on), .xfer_valid(xv), .xfer_channel(xch),
        .xfer_addr_a(xa), .xfer_addr_b(xb), .xfer_write(xw), .xfer_word(xwd), .xfer_indirect(xi),
        .bus_hold(hold), .hw_transfer_request(hw_req));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [6:0] ra(input logic [1:0] ch, input logic [2:0] idx);
        return {ch, idx, 2'b00};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the request stands until the rising edge that samples ack, then drops
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 7'h00; sel = 4'h0;
        wdat = 32'h0000_0000; req_on = 4'h0; debug_halt = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;

        rchk(ra(2'h0, REG_CONTROL), 32'h0000_0000);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0000);
        wr(ra(2'h0, REG_NEXT_LEN), 32'h0000_0003);
        rchk(ra(2'h0, REG_NEXT_LEN), 32'h0000_0003);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0008);
        wr(ra(2'h0, REG_STATUS), 32'h0000_0000);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0008);
        wr(ra(2'h0, REG_STATUS), 32'h0000_0008);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0000);
        wr(ra(2'h2, REG_BLOCK_CNT), 32'h0000_0000);
        rchk(ra(2'h2, REG_BLOCK_CNT), 32'h0000_FFFF);
        rchk(7'h01, 32'h0000_0000);
        $display("test registers done");

        // hardware request keeps the intermittent policy, reserved bit written as zero
        wr(ra(2'h0, REG_BLOCK_CNT), 32'h0000_0002);
        wr(ra(2'h0, REG_ADDR_A_CNT), 32'h0000_0010);
        wr(ra(2'h0, REG_CONTROL), 32'h0000_0603);
        rchk(ra(2'h0, REG_CONTROL), 32'h0000_0603);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0004);
        chk({31'h0, clock_enable}, 32'h0000_0001);
        debug_halt <= 1'b1;
        req_on     <= 4'h1;
        repeat (10) @(posedge clk);
        chk(32'(dma_far_end_i.xfers[0]), 32'h0000_0000);
        debug_halt <= 1'b0;
        repeat (20) @(posedge clk);
        chk(32'(dma_far_end_i.xfers[0]), 32'h0000_0002);
        chk(32'(dma_far_end_i.adjacent[0]), 32'h0000_0000);
        chk(32'(dma_far_end_i.holds[0]), 32'h0000_0000);
        chk({8'h00, dma_far_end_i.last_a}, 32'h0000_0012);
        chk({29'h0, dma_far_end_i.last_kind}, 32'h0000_0000);
        rchk(ra(2'h0, REG_BLOCK_CNT), 32'h0000_0000);
        rchk(ra(2'h0, REG_ADDR_A_CNT), 32'h0000_0014);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0003);
        chk({28'h0, irq}, 32'h0000_0001);
        wr(ra(2'h0, REG_STATUS), 32'h0000_0005);
        rchk(ra(2'h0, REG_STATUS), 32'h0000_0002);
        chk({28'h0, irq}, 32'h0000_0000);
        req_on <= 4'h0;
        $display("test fly-by block done");

        // software request only, since burst is chosen here
        wr(ra(2'h1, REG_NEXT_LEN), 32'h0000_0001);
        wr(ra(2'h1, REG_BLOCK_CNT), 32'h0000_0001);
        wr(ra(2'h1, REG_CONTROL), 32'h0000_01FD);
        rchk(ra(2'h1, REG_CONTROL), 32'h0000_01FD);
        repeat (20) @(posedge clk);
        chk(32'(dma_far_end_i.adjacent[1] > 0), 32'h0000_0001);
        chk(32'(dma_far_end_i.holds[1] > 0), 32'h0000_0001);
        chk({29'h0, dma_far_end_i.last_kind}, 32'h0000_0007);
        rchk(ra(2'h1, REG_STATUS), 32'h0000_0007);
        chk({28'h0, irq}, 32'h0000_0002);
        wr(ra(2'h1, REG_CONTROL), 32'h0000_0000);
        rchk(ra(2'h1, REG_STATUS), 32'h0000_0003);
        $display("test burst auto-init done");

        // indirect intermittent run on a long block, device B stepping down by two
        wr(ra(2'h2, REG_ADDR_B_CNT), 32'h0000_0100);
        wr(ra(2'h2, REG_CONTROL), 32'h0000_7111);
        repeat (10) @(posedge clk);
        wr(ra(2'h2, REG_CONTROL), 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(32'(dma_far_end_i.xfers[2] > 0), 32'h0000_0001);
        chk(32'(dma_far_end_i.adjacent[2]), 32'h0000_0000);
        chk({29'h0, dma_far_end_i.last_kind}, 32'h0000_0004);
        chk({8'h00, dma_far_end_i.last_b}, 32'h0000_0102 - 32'(2 * dma_far_end_i.xfers[2]));
        rchk(ra(2'h2, REG_ADDR_B_CNT), 32'h0000_0100 - 32'(2 * dma_far_end_i.xfers[2]));
        rchk(ra(2'h2, REG_BLOCK_CNT), 32'h0000_FFFF - 32'(dma_far_end_i.xfers[2]));
        $display("test indirect step done");

        // enable on an idle channel with parameters waiting loads the next block
        wr(ra(2'h3, REG_NEXT_LEN), 32'h0000_0002);
        wr(ra(2'h3, REG_CONTROL), 32'h0000_0001);
        rchk(ra(2'h3, REG_BLOCK_CNT), 32'h0000_0002);
        rchk(ra(2'h3, REG_STATUS), 32'h0000_0004);
        wr(ra(2'h3, REG_CONTROL), 32'h0000_0000);
        wr(ra(2'h0, REG_CONTROL), 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk({31'h0, clock_enable}, 32'h0000_0000);
        $display("test start and clock gate done");
        end_sim();
    end
endmodule // dma_channel_control_status_test
